/* File: dv/tb_general_timer_irq_load_match.sv */
// tb_general_timer_irq_load_match: self-checking bench for gtim_top
// assumes gtim_pkg offsets and a one-word-per-register axi4-lite slave
module tb_general_timer_irq_load_match;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, reset_n_i = 0, cap_a_i = 0, cap_b_i = 0;
  logic axi_awvalid_i = 0, axi_wvalid_i = 0, axi_bready_i = 0, axi_arvalid_i = 0;
  logic axi_rready_i = 0;
  logic [7:0] axi_awaddr_i = 0, axi_araddr_i = 0;
  logic [31:0] axi_wdata_i = 0, axi_rdata_o, v;
  logic [3:0] axi_wstrb_i = 4'hF;
  logic axi_awready_o, axi_wready_o, axi_bvalid_o, axi_arready_o, axi_rvalid_o;
  logic pwm_a_o, pwm_b_o, irq_o;
  logic [1:0] axi_bresp_o, axi_rresp_o;
  int n_errors = 0, checks = 0, h;
  // device under test
  gtim_top i_dut (.clk_i, .reset_n_i, .axi_awvalid_i, .axi_awready_o, .axi_awaddr_i,
    .axi_wvalid_i, .axi_wready_o, .axi_wdata_i, .axi_wstrb_i, .axi_bvalid_o,
    .axi_bready_i, .axi_bresp_o, .axi_arvalid_i, .axi_arready_o, .axi_araddr_i,
    .axi_rvalid_o, .axi_rready_i, .axi_rdata_o, .axi_rresp_o, .cap_a_i, .cap_b_i,
    .pwm_a_o, .pwm_b_o, .irq_o);
  // 40 mhz clock
  always #12.5 clk_i = ~clk_i;
  // counts, verdict and end of run
  task automatic complete_run();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // compares one value and counts it
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // ends a wait that runs too long
  task automatic guard(input int n);
    if (n > 300) begin
      n_errors++;
      complete_run();
    end
  endtask
  // one write, address and data offered together, response checked
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 0);
    int n;
    logic da, dw, ta, tw, hit;
    logic [1:0] r;
    n = 0;
    da = 0;
    dw = 0;
    hit = 0;
    @(posedge clk_i);
    axi_awvalid_i <= 1;
    axi_wvalid_i <= 1;
    axi_awaddr_i <= a;
    axi_wdata_i <= d;
    axi_bready_i <= 1;
    while (!hit) begin
      @(negedge clk_i);
      ta = axi_awready_o && !da;
      tw = axi_wready_o && !dw;
      hit = axi_bvalid_o;
      r = axi_bresp_o;
      @(posedge clk_i);
      if (ta) axi_awvalid_i <= 0;
      if (tw) axi_wvalid_i <= 0;
      da = da | ta;
      dw = dw | tw;
      n++;
      guard(n);
    end
    axi_bready_i <= 0;
    chk(r, er);
  endtask
  // one read, response checked and data returned
  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = 0);
    int n;
    logic ta, hit;
    logic [1:0] r;
    n = 0;
    hit = 0;
    @(posedge clk_i);
    axi_arvalid_i <= 1;
    axi_araddr_i <= a;
    axi_rready_i <= 1;
    while (!hit) begin
      @(negedge clk_i);
      ta = axi_arready_o && axi_arvalid_i;
      hit = axi_rvalid_o;
      d = axi_rdata_o;
      r = axi_rresp_o;
      @(posedge clk_i);
      if (ta) axi_arvalid_i <= 0;
      n++;
      guard(n);
    end
    axi_rready_i <= 0;
    chk(r, er);
  endtask
  // read and compare in one step
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 0);
    logic [31:0] d;
    rd(a, d, er);
    chk(d, e);
  endtask
  // waits for the interrupt line under a bound
  task automatic wirq();
    int n = 0;
    @(negedge clk_i);
    while (irq_o !== 1'b1) begin
      @(negedge clk_i);
      n++;
      guard(n);
    end
  endtask
  // one rising edge on capture input a
  task automatic pulse();
    @(posedge clk_i);
    cap_a_i <= 1;
    repeat (2) @(posedge clk_i);
    cap_a_i <= 0;
    @(posedge clk_i);
  endtask
  // readback of value registers, narrow fields and an unmapped word
  task automatic s_regs();
    rc(gtim_pkg::OFF_IRQ_EN, 32'h0000_0000);
    wr(gtim_pkg::OFF_LOAD_A, 32'h1234_5678);
    rc(gtim_pkg::OFF_LOAD_A, 32'h1234_5678);
    wr(gtim_pkg::OFF_PRE_A, 32'hFFFF_FFFF);
    rc(gtim_pkg::OFF_PRE_A, 32'h0000_00FF);
    wr(gtim_pkg::OFF_PMATCH_B, 32'h0000_01A5);
    rc(gtim_pkg::OFF_PMATCH_B, 32'h0000_00A5);
    wr(gtim_pkg::OFF_MATCH_A, 32'h0BAD_F00D);
    rc(gtim_pkg::OFF_MATCH_A, 32'h0BAD_F00D);
    wr(8'h80, 32'h1, gtim_pkg::RESP_SLVERR);
    rc(8'h80, 32'h0, gtim_pkg::RESP_SLVERR);
    wr(gtim_pkg::OFF_PRE_A, 32'h0);
    wr(gtim_pkg::OFF_MATCH_A, 32'h0);
  endtask
  // timeouts on both halves, masking, raw and masked status, clearing
  task automatic s_irq();
    wr(gtim_pkg::OFF_IRQ_EN, 32'h0000_0001);
    wr(gtim_pkg::OFF_MODE_A, 32'h1);
    wr(gtim_pkg::OFF_MODE_B, 32'h1);
    wr(gtim_pkg::OFF_LOAD_A, 32'h5);
    wr(gtim_pkg::OFF_LOAD_B, 32'h3);
    wr(gtim_pkg::OFF_CTL, 32'h3);
    wirq();
    wr(gtim_pkg::OFF_CTL, 32'h0);
    rc(gtim_pkg::OFF_IRQ_RAW, 32'h0000_0011);
    rc(gtim_pkg::OFF_IRQ_MSK, 32'h0000_0001);
    wr(gtim_pkg::OFF_IRQ_CLR, 32'h0);
    rc(gtim_pkg::OFF_IRQ_RAW, 32'h0000_0011);
    @(negedge clk_i);
    chk({31'h0, irq_o}, 32'h1);
    wr(gtim_pkg::OFF_IRQ_CLR, 32'h1);
    rc(gtim_pkg::OFF_IRQ_RAW, 32'h0000_0010);
    @(negedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    wr(gtim_pkg::OFF_IRQ_EN, 32'h0000_0010);
    @(negedge clk_i);
    chk({31'h0, irq_o}, 32'h1);
    wr(gtim_pkg::OFF_IRQ_CLR, 32'h0000_0010);
    rc(gtim_pkg::OFF_IRQ_MSK, 32'h0);
  endtask
  // a load written while counting takes over the counter one cycle after the write
  task automatic s_reload();
    wr(gtim_pkg::OFF_MODE_A, 32'h0);
    wr(gtim_pkg::OFF_LOAD_A, 32'h0000_F000);
    wr(gtim_pkg::OFF_CTL, 32'h1);
    wr(gtim_pkg::OFF_LOAD_A, 32'h0000_0100);
    rd(gtim_pkg::OFF_VALUE_A, v);
    chk({31'h0, v <= 32'h100 && v >= 32'hE0}, 32'h1);
  endtask
  // edge count reaching match raises capture match on the third edge
  task automatic s_capcount();
    wr(gtim_pkg::OFF_CTL, 32'h0);
    wr(gtim_pkg::OFF_IRQ_CLR, 32'h7F);
    wr(gtim_pkg::OFF_MODE_A, 32'hA);
    wr(gtim_pkg::OFF_LOAD_A, 32'h10);
    wr(gtim_pkg::OFF_MATCH_A, 32'h3);
    wr(gtim_pkg::OFF_CTL, 32'h1);
    pulse();
    pulse();
    rc(gtim_pkg::OFF_IRQ_RAW, 32'h0);
    pulse();
    rc(gtim_pkg::OFF_IRQ_RAW, 32'h0000_0002);
  endtask
  // pwm idle level follows inversion, duty set by match against load
  task automatic s_pwm();
    wr(gtim_pkg::OFF_CTL, 32'hC);
    wr(gtim_pkg::OFF_MODE_A, 32'h4);
    wr(gtim_pkg::OFF_LOAD_A, 32'hA);
    wr(gtim_pkg::OFF_MATCH_A, 32'h4);
    @(negedge clk_i);
    chk({31'h0, pwm_a_o}, 32'h1);
    chk({31'h0, pwm_b_o}, 32'h1);
    wr(gtim_pkg::OFF_CTL, 32'h1);
    @(negedge clk_i);
    chk({31'h0, pwm_b_o}, 32'h0);
    h = 0;
    repeat (220) begin
      @(negedge clk_i);
      h += (pwm_a_o === 1'b1);
    end
    chk({31'h0, h >= 108 && h <= 132}, 32'h1);
  endtask
  // wide mode ignores the prescaler, so the short load still times out
  task automatic s_wide();
    wr(gtim_pkg::OFF_CTL, 32'h0);
    wr(gtim_pkg::OFF_IRQ_CLR, 32'h7F);
    wr(gtim_pkg::OFF_CFG, 32'h1);
    wr(gtim_pkg::OFF_MODE_A, 32'h1);
    wr(gtim_pkg::OFF_PRE_A, 32'hFF);
    wr(gtim_pkg::OFF_LOAD_A, 32'h5);
    wr(gtim_pkg::OFF_IRQ_EN, 32'h1);
    wr(gtim_pkg::OFF_CTL, 32'h1);
    wirq();
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge clk_i);
    reset_n_i <= 1;
    s_regs();
    s_irq();
    s_reload();
    s_capcount();
    s_pwm();
    s_wide();
    complete_run();
  end
endmodule

/* File: verilog/gtim_half.sv */
// gtim_half: one half-timer counter with prescale extension and pwm
// assumes registers held by the parent; cap_i is synchronous to clk_i
module gtim_half (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // configuration
  input wire logic en_i,
  input wire logic wide_i,
  input wire gtim_pkg::gtim_mode_type mode_i,
  input wire logic up_i,
  input wire logic inv_i,
  input wire logic [31:0] load_i,
  input wire logic [31:0] match_i,
  input wire logic [7:0] pre_i,
  input wire logic [7:0] pmatch_i,
  input wire logic load_wr_i,
  // capture pin
  input wire logic cap_i,
  // results
  output logic [31:0] value_o,
  output logic timeout_o,
  output logic match_o,
  output logic event_o,
  output logic pwm_o
);
  logic [31:0] lim, mat, start, nxt, cnt_q, hold_q;
  logic at_end, edge_hit, timed;
  logic cap_q, done_q, tmo_q, mat_q, evt_q, pwm_q;

  // prescaler forms the upper byte only in 16-bit modes
  assign lim = wide_i ? load_i : {8'h00, pre_i, load_i[15:0]};
  assign mat = wide_i ? match_i : {8'h00, pmatch_i, match_i[15:0]};
  assign start = up_i ? gtim_pkg::ZERO32 : lim;
  assign nxt = gtim_pkg::gtim_step(cnt_q, up_i);
  assign at_end = up_i ? (cnt_q == lim) : (cnt_q == gtim_pkg::ZERO32);
  assign edge_hit = cap_i & ~cap_q;
  assign timed = (mode_i == gtim_pkg::GTIM_ONESHOT) || (mode_i == gtim_pkg::GTIM_PERIODIC);

  // counter, per-mode behaviour and event pulses
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q <= 32'h0000_0000;
      hold_q <= 32'h0000_0000;
      cap_q <= 1'b0;
      done_q <= 1'b0;
      tmo_q <= 1'b0;
      mat_q <= 1'b0;
      evt_q <= 1'b0;
    end else begin
      cap_q <= cap_i;
      tmo_q <= 1'b0;
      mat_q <= 1'b0;
      evt_q <= 1'b0;
      if (!en_i || load_wr_i) begin
        cnt_q <= start;
        done_q <= 1'b0;
      end else begin
        unique case (mode_i)
          gtim_pkg::GTIM_ONESHOT, gtim_pkg::GTIM_PERIODIC: begin
            if (!done_q) begin
              mat_q <= (nxt == mat);
              if (at_end) begin
                tmo_q <= 1'b1;
                cnt_q <= start;
                done_q <= (mode_i == gtim_pkg::GTIM_ONESHOT);
              end else begin
                cnt_q <= nxt;
              end
            end
          end
          gtim_pkg::GTIM_CAPCOUNT: begin
            if (edge_hit) begin
              if (nxt == mat) begin
                mat_q <= 1'b1;
                cnt_q <= start;
              end else begin
                cnt_q <= nxt;
              end
            end
          end
          gtim_pkg::GTIM_CAPTIME: begin
            cnt_q <= at_end ? start : nxt;
            if (edge_hit) begin
              hold_q <= cnt_q;
              evt_q <= 1'b1;
            end
          end
          gtim_pkg::GTIM_PWM: begin
            cnt_q <= at_end ? start : nxt;
          end
          default: begin
            cnt_q <= cnt_q;
          end
        endcase
      end
    end
  end

  // pwm level: active while above match, polarity by invert
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pwm_q <= 1'b0;
    end else if (en_i && mode_i == gtim_pkg::GTIM_PWM) begin
      pwm_q <= (cnt_q > mat) ^ inv_i;
    end else begin
      pwm_q <= inv_i;
    end
  end

  assign value_o = (mode_i == gtim_pkg::GTIM_CAPTIME) ? hold_q : cnt_q;
  assign timeout_o = tmo_q;
  assign match_o = mat_q;
  assign event_o = evt_q;
  assign pwm_o = pwm_q;

  load_now_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    en_i && load_wr_i |=> cnt_q == $past(start))
    else $error("load write did not reach the counter at once");
  tmo_mode_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    timeout_o |-> $past(timed) && $past(at_end))
    else $error("timeout outside timer modes or before end of count");
  pwm_pol_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    en_i && mode_i == gtim_pkg::GTIM_PWM && cnt_q > mat ##1 $stable(inv_i)
    |-> pwm_o == !inv_i)
    else $error("pwm active level wrong for polarity");
  pre_off_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    wide_i |-> lim == load_i && mat == match_i)
    else $error("prescaler leaked into 32-bit mode");
endmodule

/* File: verilog/gtim_pkg.sv */
// gtim_pkg: register map, field positions, modes and helpers of the timer
// assumes a 32-bit AXI4-Lite register port with byte addresses
package gtim_pkg;
  // byte offsets of the register words
  localparam logic [7:0] OFF_CFG = 8'h00;
  localparam logic [7:0] OFF_CTL = 8'h04;
  localparam logic [7:0] OFF_MODE_A = 8'h08;
  localparam logic [7:0] OFF_MODE_B = 8'h0C;
  localparam logic [7:0] OFF_LOAD_A = 8'h10;
  localparam logic [7:0] OFF_LOAD_B = 8'h14;
  localparam logic [7:0] OFF_MATCH_A = 8'h18;
  localparam logic [7:0] OFF_MATCH_B = 8'h1C;
  localparam logic [7:0] OFF_PRE_A = 8'h20;
  localparam logic [7:0] OFF_PRE_B = 8'h24;
  localparam logic [7:0] OFF_PMATCH_A = 8'h28;
  localparam logic [7:0] OFF_PMATCH_B = 8'h2C;
  localparam logic [7:0] OFF_IRQ_EN = 8'h30;
  localparam logic [7:0] OFF_IRQ_RAW = 8'h34;
  localparam logic [7:0] OFF_IRQ_MSK = 8'h38;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h3C;
  localparam logic [7:0] OFF_VALUE_A = 8'h40;
  localparam logic [7:0] OFF_VALUE_B = 8'h44;
  // field positions
  localparam int CFG_WIDE = 0;
  localparam int CFG_RTC = 1;
  localparam int CTL_EN_A = 0;
  localparam int CTL_EN_B = 1;
  localparam int CTL_INV_A = 2;
  localparam int CTL_INV_B = 3;
  localparam int MODE_UP = 3;
  // interrupt source bits
  localparam int IRQ_A_TMO = 0;
  localparam int IRQ_A_CAPM = 1;
  localparam int IRQ_A_CAPE = 2;
  localparam int IRQ_RTC = 3;
  localparam int IRQ_B_TMO = 4;
  localparam int IRQ_B_CAPM = 5;
  localparam int IRQ_B_CAPE = 6;
  localparam int IRQ_N = 7;
  // reset values and responses
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
  localparam logic [31:0] ONE32 = 32'h0000_0001;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // per-half operating modes
  typedef enum logic [2:0] {
    GTIM_ONESHOT = 3'b000,
    GTIM_PERIODIC = 3'b001,
    GTIM_CAPCOUNT = 3'b010,
    GTIM_CAPTIME = 3'b011,
    GTIM_PWM = 3'b100
  } gtim_mode_type;
  // byte-lane merge of a write into a register word
  function automatic logic [31:0] gtim_merge(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] strb);
    logic [31:0] m;
    m = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) m[8*i +: 8] = new_v[8*i +: 8];
    end
    return m;
  endfunction
  // one count step up or down
  function automatic logic [31:0] gtim_step(input logic [31:0] v, input logic up);
    return up ? v + ONE32 : v - ONE32;
  endfunction
endpackage

/* File: verilog/gtim_top.sv */
// gtim_top: general timer with two halves, match, prescale and interrupts
// assumes an AXI4-Lite master on clk_i and capture pins synchronous to it
// Summary of operation
// - seven sources: capture event, capture match, timeout per half, RTC match.
// - each source has an enable; only enabled sources reach the interrupt line.
// - software reads raw status and masked status, raw ANDed with enables.
// - a clear naming sources by bit mask deasserts exactly those sources that have no new event in the same cycle.
// - a pending source stays set until software clears it.
// - writing load while running reloads the counter one cycle after the write.
// - load, match, prescale and prescale match read back as programmed.
// - edge-count capture raises capture match when the count reaches match.
// - in PWM mode match sets the duty cycle against load.
// - in 32-bit mode only half A load, match and value are used.
// - prescaler works only in 16-bit modes; no effect in 32-bit modes.
// - prescale match forms the upper match bits, giving 24-bit compare.
// - prescale and prescale match are 8 bits, values 0 to 255.
// - each 16-bit half does one-shot, periodic, captures and PWM, up or down.
// - PWM output active low when inverted, active high otherwise.
module gtim_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // axi4-lite write address and data
  input wire logic axi_awvalid_i,
  output logic axi_awready_o,
  input wire logic [7:0] axi_awaddr_i,
  input wire logic axi_wvalid_i,
  output logic axi_wready_o,
  input wire logic [31:0] axi_wdata_i,
  input wire logic [3:0] axi_wstrb_i,
  // axi4-lite write response
  output logic axi_bvalid_o,
  input wire logic axi_bready_i,
  output logic [1:0] axi_bresp_o,
  // axi4-lite read
  input wire logic axi_arvalid_i,
  output logic axi_arready_o,
  input wire logic [7:0] axi_araddr_i,
  output logic axi_rvalid_o,
  input wire logic axi_rready_i,
  output logic [31:0] axi_rdata_o,
  output logic [1:0] axi_rresp_o,
  // timer pins
  input wire logic cap_a_i,
  input wire logic cap_b_i,
  output logic pwm_a_o,
  output logic pwm_b_o,
  // interrupt
  output logic irq_o
);
  logic aw_got_q, w_got_q, bvalid_q, rvalid_q;
  logic [7:0] waddr_q, raddr_q;
  logic [31:0] wdata_q, rdata_q, rd_d;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic wr_go, ld_a_q, ld_b_q, wide, en_b;
  logic [1:0] cfg_q;
  logic [3:0] ctl_q, mode_a_q, mode_b_q;
  logic [31:0] load_a_q, match_a_q, val_a, val_b;
  logic [15:0] load_b_q, match_b_q;
  logic [7:0] pre_a_q, pre_b_q, pm_a_q, pm_b_q;
  logic [gtim_pkg::IRQ_N-1:0] imr_q, ris_q, ev, clr;
  logic tmo_a, tmo_b, mt_a, mt_b, ce_a, ce_b;
  gtim_pkg::gtim_mode_type md_a, md_b;

  // true for every word address that holds a register
  function automatic logic mapped(input logic [7:0] a);
    unique case (a)
      gtim_pkg::OFF_CFG, gtim_pkg::OFF_CTL, gtim_pkg::OFF_MODE_A,
      gtim_pkg::OFF_MODE_B, gtim_pkg::OFF_LOAD_A, gtim_pkg::OFF_LOAD_B,
      gtim_pkg::OFF_MATCH_A, gtim_pkg::OFF_MATCH_B, gtim_pkg::OFF_PRE_A,
      gtim_pkg::OFF_PRE_B, gtim_pkg::OFF_PMATCH_A, gtim_pkg::OFF_PMATCH_B,
      gtim_pkg::OFF_IRQ_EN, gtim_pkg::OFF_IRQ_RAW, gtim_pkg::OFF_IRQ_MSK,
      gtim_pkg::OFF_IRQ_CLR, gtim_pkg::OFF_VALUE_A, gtim_pkg::OFF_VALUE_B: begin
        return 1'b1;
      end
      default: begin
        return 1'b0;
      end
    endcase
  endfunction

  // write path handshakes: address and data in either order
  assign axi_awready_o = !aw_got_q && !bvalid_q;
  assign axi_wready_o = !w_got_q && !bvalid_q;
  assign wr_go = aw_got_q && w_got_q && !bvalid_q;
  assign axi_bvalid_o = bvalid_q;
  assign axi_bresp_o = bresp_q;

  // collect address and data, answer once both are held
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      waddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (axi_awvalid_i && axi_awready_o) begin
        aw_got_q <= 1'b1;
        waddr_q <= {axi_awaddr_i[7:2], 2'h0};
      end
      if (axi_wvalid_i && axi_wready_o) begin
        w_got_q <= 1'b1;
        wdata_q <= axi_wdata_i;
        wstrb_q <= axi_wstrb_i;
      end
      if (wr_go) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= mapped(waddr_q) ? gtim_pkg::RESP_OKAY : gtim_pkg::RESP_SLVERR;
      end else if (bvalid_q && axi_bready_i) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // software-written configuration, values and enables
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg_q <= 2'h0;
      ctl_q <= 4'h0;
      mode_a_q <= 4'h0;
      mode_b_q <= 4'h0;
      load_a_q <= 32'h0000_0000;
      load_b_q <= 16'h0000;
      match_a_q <= 32'h0000_0000;
      match_b_q <= 16'h0000;
      pre_a_q <= 8'h00;
      pre_b_q <= 8'h00;
      pm_a_q <= 8'h00;
      pm_b_q <= 8'h00;
      imr_q <= 7'h00;
    end else if (wr_go) begin
      unique case (waddr_q)
        gtim_pkg::OFF_CFG: cfg_q <= 2'(gtim_pkg::gtim_merge({30'h0, cfg_q},
            wdata_q, wstrb_q));
        gtim_pkg::OFF_CTL: ctl_q <= 4'(gtim_pkg::gtim_merge({28'h0, ctl_q},
            wdata_q, wstrb_q));
        gtim_pkg::OFF_MODE_A: mode_a_q <= 4'(gtim_pkg::gtim_merge({28'h0, mode_a_q},
            wdata_q, wstrb_q));
        gtim_pkg::OFF_MODE_B: mode_b_q <= 4'(gtim_pkg::gtim_merge({28'h0, mode_b_q},
            wdata_q, wstrb_q));
        gtim_pkg::OFF_LOAD_A: load_a_q <= gtim_pkg::gtim_merge(load_a_q,
            wdata_q, wstrb_q);
        gtim_pkg::OFF_LOAD_B: load_b_q <= 16'(gtim_pkg::gtim_merge({16'h0, load_b_q},
            wdata_q, wstrb_q));
        gtim_pkg::OFF_MATCH_A: match_a_q <= gtim_pkg::gtim_merge(match_a_q,
            wdata_q, wstrb_q);
        gtim_pkg::OFF_MATCH_B: match_b_q <= 16'(gtim_pkg::gtim_merge({16'h0, match_b_q},
            wdata_q, wstrb_q));
        gtim_pkg::OFF_PRE_A: pre_a_q <= 8'(gtim_pkg::gtim_merge({24'h0, pre_a_q},
            wdata_q, wstrb_q));
        gtim_pkg::OFF_PRE_B: pre_b_q <= 8'(gtim_pkg::gtim_merge({24'h0, pre_b_q},
            wdata_q, wstrb_q));
        gtim_pkg::OFF_PMATCH_A: pm_a_q <= 8'(gtim_pkg::gtim_merge({24'h0, pm_a_q},
            wdata_q, wstrb_q));
        gtim_pkg::OFF_PMATCH_B: pm_b_q <= 8'(gtim_pkg::gtim_merge({24'h0, pm_b_q},
            wdata_q, wstrb_q));
        gtim_pkg::OFF_IRQ_EN: imr_q <= 7'(gtim_pkg::gtim_merge({25'h0, imr_q},
            wdata_q, wstrb_q));
        default: begin
          cfg_q <= cfg_q;
        end
      endcase
    end
  end

  // a load write restarts its half one cycle later, from the new value counting down, from zero counting up
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ld_a_q <= 1'b0;
      ld_b_q <= 1'b0;
    end else begin
      ld_a_q <= wr_go && waddr_q == gtim_pkg::OFF_LOAD_A;
      ld_b_q <= wr_go && waddr_q == gtim_pkg::OFF_LOAD_B;
    end
  end

  // half B sits idle while A runs as one 32-bit timer
  assign wide = cfg_q[gtim_pkg::CFG_WIDE];
  assign en_b = ctl_q[gtim_pkg::CTL_EN_B] && !wide;
  assign md_a = gtim_pkg::gtim_mode_type'(mode_a_q[2:0]);
  assign md_b = gtim_pkg::gtim_mode_type'(mode_b_q[2:0]);

  gtim_half u_half_a (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .en_i(ctl_q[gtim_pkg::CTL_EN_A]),
    .wide_i(wide),
    .mode_i(md_a),
    .up_i(mode_a_q[gtim_pkg::MODE_UP]),
    .inv_i(ctl_q[gtim_pkg::CTL_INV_A]),
    .load_i(load_a_q),
    .match_i(match_a_q),
    .pre_i(pre_a_q),
    .pmatch_i(pm_a_q),
    .load_wr_i(ld_a_q),
    .cap_i(cap_a_i),
    .value_o(val_a),
    .timeout_o(tmo_a),
    .match_o(mt_a),
    .event_o(ce_a),
    .pwm_o(pwm_a_o)
  );

  gtim_half u_half_b (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .en_i(en_b),
    .wide_i(1'b0),
    .mode_i(md_b),
    .up_i(mode_b_q[gtim_pkg::MODE_UP]),
    .inv_i(ctl_q[gtim_pkg::CTL_INV_B]),
    .load_i({16'h0000, load_b_q}),
    .match_i({16'h0000, match_b_q}),
    .pre_i(pre_b_q),
    .pmatch_i(pm_b_q),
    .load_wr_i(ld_b_q),
    .cap_i(cap_b_i),
    .value_o(val_b),
    .timeout_o(tmo_b),
    .match_o(mt_b),
    .event_o(ce_b),
    .pwm_o(pwm_b_o)
  );

  // source events, one bit each
  always_comb begin
    ev = 7'h00;
    ev[gtim_pkg::IRQ_A_TMO] = tmo_a;
    ev[gtim_pkg::IRQ_A_CAPM] = mt_a && md_a == gtim_pkg::GTIM_CAPCOUNT;
    ev[gtim_pkg::IRQ_A_CAPE] = ce_a;
    ev[gtim_pkg::IRQ_RTC] = mt_a && wide && cfg_q[gtim_pkg::CFG_RTC];
    ev[gtim_pkg::IRQ_B_TMO] = tmo_b;
    ev[gtim_pkg::IRQ_B_CAPM] = mt_b && md_b == gtim_pkg::GTIM_CAPCOUNT;
    ev[gtim_pkg::IRQ_B_CAPE] = ce_b;
  end

  // write-one-to-clear mask
  assign clr = (wr_go && waddr_q == gtim_pkg::OFF_IRQ_CLR) ?
      7'(gtim_pkg::gtim_merge(gtim_pkg::ZERO32, wdata_q, wstrb_q)) : 7'h00;

  // sticky raw status, a new event wins over its clear
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ris_q <= 7'h00;
    end else begin
      ris_q <= (ris_q & ~clr) | ev;
    end
  end

  assign irq_o = |(ris_q & imr_q);

  // read data for the addressed word
  always_comb begin
    rd_d = 32'h0000_0000;
    unique case ({axi_araddr_i[7:2], 2'h0})
      gtim_pkg::OFF_CFG: rd_d = {30'h0, cfg_q};
      gtim_pkg::OFF_CTL: rd_d = {28'h0, ctl_q};
      gtim_pkg::OFF_MODE_A: rd_d = {28'h0, mode_a_q};
      gtim_pkg::OFF_MODE_B: rd_d = {28'h0, mode_b_q};
      gtim_pkg::OFF_LOAD_A: rd_d = load_a_q;
      gtim_pkg::OFF_LOAD_B: rd_d = {16'h0, load_b_q};
      gtim_pkg::OFF_MATCH_A: rd_d = match_a_q;
      gtim_pkg::OFF_MATCH_B: rd_d = {16'h0, match_b_q};
      gtim_pkg::OFF_PRE_A: rd_d = {24'h0, pre_a_q};
      gtim_pkg::OFF_PRE_B: rd_d = {24'h0, pre_b_q};
      gtim_pkg::OFF_PMATCH_A: rd_d = {24'h0, pm_a_q};
      gtim_pkg::OFF_PMATCH_B: rd_d = {24'h0, pm_b_q};
      gtim_pkg::OFF_IRQ_EN: rd_d = {25'h0, imr_q};
      gtim_pkg::OFF_IRQ_RAW: rd_d = {25'h0, ris_q};
      gtim_pkg::OFF_IRQ_MSK: rd_d = {25'h0, ris_q & imr_q};
      gtim_pkg::OFF_VALUE_A: rd_d = val_a;
      gtim_pkg::OFF_VALUE_B: rd_d = val_b;
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // read channel: one read at a time, data registered
  assign axi_arready_o = !rvalid_q;
  assign axi_rvalid_o = rvalid_q;
  assign axi_rdata_o = rdata_q;
  assign axi_rresp_o = rresp_q;

  // take a read address and hold the answer until the master accepts it
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'h0;
      raddr_q <= 8'h00;
    end else if (axi_arvalid_i && axi_arready_o) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_d;
      raddr_q <= {axi_araddr_i[7:2], 2'h0};
      rresp_q <= mapped({axi_araddr_i[7:2], 2'h0}) ?
          gtim_pkg::RESP_OKAY : gtim_pkg::RESP_SLVERR;
    end else if (rvalid_q && axi_rready_i) begin
      rvalid_q <= 1'b0;
    end
  end

  // steps of a clear write and of a masked-status read
  sequence clr_write_s;
    wr_go && waddr_q == gtim_pkg::OFF_IRQ_CLR;
  endsequence
  sequence mis_read_s;
    $rose(rvalid_q) && raddr_q == gtim_pkg::OFF_IRQ_MSK;
  endsequence

  // status, masking and clear checks
  mask_gate_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    imr_q == 7'h00 |-> !irq_o)
    else $error("interrupt raised with all sources disabled");
  mis_read_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    mis_read_s |-> rdata_q == {25'h0, $past(ris_q) & $past(imr_q)})
    else $error("masked status read is not raw and enables");
  clear_mask_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    clr_write_s |=> (ris_q & $past(clr) & ~$past(ev)) == 7'h00)
    else $error("cleared source still set");
  clear_keep_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    clr_write_s |=> (($past(ris_q) & ~$past(clr)) & ~ris_q) == 7'h00)
    else $error("clear touched a source not named");
  sticky_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ##1 ($past(ris_q) & ~$past(clr) & ~ris_q) == 7'h00)
    else $error("pending source dropped without a clear");
  capm_flag_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    mt_a && md_a == gtim_pkg::GTIM_CAPCOUNT |=> ris_q[gtim_pkg::IRQ_A_CAPM])
    else $error("capture match did not set its status");
  wide_b_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    wide ##1 wide |-> !tmo_b && !ce_b && !mt_b)
    else $error("half B active in 32-bit mode");

  // a timeout pulse from either half lands in its status bit
  tmo_a_flag_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    tmo_a |=> ris_q[gtim_pkg::IRQ_A_TMO])
    else $error("half A timeout did not set its status");
  tmo_b_flag_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    tmo_b |=> ris_q[gtim_pkg::IRQ_B_TMO])
    else $error("half B timeout did not set its status");
endmodule
